// ### rtl/io_ports_pkg.sv
// shared constants and types for the configurable io port block
package io_ports_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int C_W = 8;
    localparam int A_W = 4;

    localparam logic [ADDR_W-1:0] OFF_DIR = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_TRIS = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_LVL = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_FIXED = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_FIRST = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_ANMODE = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_PINCMD = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_SFEN = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_RAWTRIS = 6'h20;

    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_TRIS = 8'hFF;
    localparam logic [7:0] RST_LVL = 8'h00;
    localparam logic [7:0] RST_FIXED = 8'h00;
    localparam logic [3:0] RST_ANMODE = 4'hF;
    localparam logic [3:0] RST_SFEN = 4'h0;

    localparam int PINCMD_SEL_LSB = 0;
    localparam int PINCMD_LVL_BIT = 3;
    localparam int SF_IR = 0;
    localparam int SF_PWM = 1;
    localparam int SF_I2C = 2;
    localparam int SF_KBD = 3;
    localparam int PIN_IR = 0;
    localparam int PIN_PWM1 = 1;
    localparam int PIN_PWM2 = 2;
    localparam int PIN_SCL = 3;
    localparam int PIN_SDA = 4;
    localparam int PIN_KCLK = 6;
    localparam int PIN_KDAT = 7;

    localparam int CLK_NS = 5;
    localparam int REFRESH_NS = 1000;
    localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] pwm;
        logic scl_low;
        logic sda_low;
    } sf_drive_t;

    typedef struct packed {
        logic ir;
        logic scl;
        logic sda;
        logic kbd_clk;
        logic kbd_data;
    } sf_sense_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;
endpackage : io_ports_pkg

// ### rtl/sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = meta_r;
        q_nxt = q_r;
        if (ce) begin
            meta_nxt = d;
            q_nxt = meta_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : sync2

// ### rtl/pin_function_mux.sv
// per-pin selection between plain io and special functions
`timescale 1ns/1ps
module pin_function_mux
    import io_ports_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [C_W-1:0] lvl,
    input wire logic [C_W-1:0] tris_hw,
    input wire logic [3:0] sf_en,
    input wire io_ports_pkg::sf_drive_t drive,
    output logic [C_W-1:0] pin_out,
    output logic [C_W-1:0] pin_oe
);
    logic [C_W-1:0] out_r;
    logic [C_W-1:0] out_nxt;
    logic [C_W-1:0] oe_r;
    logic [C_W-1:0] oe_nxt;

    always_comb begin
        out_nxt = out_r;
        oe_nxt = oe_r;
        if (ce) begin
            out_nxt = lvl;
            oe_nxt = ~tris_hw;
            if (sf_en[SF_IR]) begin
                oe_nxt[PIN_IR] = 1'b0;
            end
            if (sf_en[SF_PWM]) begin
                out_nxt[PIN_PWM1] = drive.pwm[0];
                out_nxt[PIN_PWM2] = drive.pwm[1];
                oe_nxt[PIN_PWM1] = 1'b1;
                oe_nxt[PIN_PWM2] = 1'b1;
            end
            // open drain: only ever pull low
            if (sf_en[SF_I2C]) begin
                out_nxt[PIN_SCL] = 1'b0;
                out_nxt[PIN_SDA] = 1'b0;
                oe_nxt[PIN_SCL] = drive.scl_low;
                oe_nxt[PIN_SDA] = drive.sda_low;
            end
            if (sf_en[SF_KBD]) begin
                oe_nxt[PIN_KCLK] = 1'b0;
                oe_nxt[PIN_KDAT] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_r <= RST_LVL;
            oe_r <= ~RST_TRIS;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign pin_out = out_r;
    assign pin_oe = oe_r;
endmodule : pin_function_mux

// ### rtl/configurable_io_ports.sv
// configurable io ports with axi4-lite register access
// Operation
// - power-up gives eight digital inputs, eight outputs, four analogue inputs
// - first port bits 0..3 default analogue, also readable as digital levels
// - second port has eight outputs whose direction never changes
// - third port starts as inputs; any of its eight may become outputs
// - direction register bit 1 means output, 0 means input
// - tristate register shows direction inverted: 1 input, 0 output
// - hardware tristate is refreshed from the firmware copy; raw writes are lost
// - set-high or set-low command makes one pin output and drives level together
// - writing the level register sets all third-port outputs at once
// - special functions take over pins 0,1,2,3,4,6,7 of third port
`timescale 1ns/1ps
module configurable_io_ports
    import io_ports_pkg::*;
#(
    parameter int REFRESH_CYCLES = REFRESH_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [io_ports_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [io_ports_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [io_ports_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [io_ports_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic [io_ports_pkg::A_W-1:0] first_in,
    output logic [io_ports_pkg::A_W-1:0] first_analog_sel,
    output logic [io_ports_pkg::C_W-1:0] fixed_output_port,
    input wire logic [io_ports_pkg::C_W-1:0] third_in,
    output logic [io_ports_pkg::C_W-1:0] third_out,
    output logic [io_ports_pkg::C_W-1:0] third_oe,
    input wire io_ports_pkg::sf_drive_t sf_drive,
    output io_ports_pkg::sf_sense_t sf_sense
);
    import io_ports_pkg::*;

    localparam int CNT_W = $clog2(REFRESH_CYCLES + 1);

    if (REFRESH_CYCLES < 2) begin : g_bad_refresh
        $error("REFRESH_CYCLES must be at least 2");
    end

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFF_DIR) || (a == OFF_TRIS) || (a == OFF_LVL) || (a == OFF_FIXED)
            || (a == OFF_FIRST) || (a == OFF_ANMODE) || (a == OFF_PINCMD) || (a == OFF_SFEN)
            || (a == OFF_RAWTRIS);
    endfunction : mapped

    // synchronised pin levels
    logic [A_W-1:0] first_sync;
    logic [C_W-1:0] third_sync;

    sync2 #(.W(A_W + C_W)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({first_in, third_in}),
        .q({first_sync, third_sync})
    );

    // register state
    logic [C_W-1:0] dir_r;
    logic [C_W-1:0] dir_nxt;
    logic [C_W-1:0] tris_hw_r;
    logic [C_W-1:0] tris_hw_nxt;
    logic [C_W-1:0] lvl_r;
    logic [C_W-1:0] lvl_nxt;
    logic [C_W-1:0] fixed_r;
    logic [C_W-1:0] fixed_nxt;
    logic [A_W-1:0] anmode_r;
    logic [A_W-1:0] anmode_nxt;
    logic [3:0] sfen_r;
    logic [3:0] sfen_nxt;
    logic [CNT_W-1:0] refresh_cnt_r;
    logic [CNT_W-1:0] refresh_cnt_nxt;
    logic refresh;

    // write channel state
    wr_state_t wr_state_r;
    wr_state_t wr_state_nxt;
    logic aw_have_r;
    logic aw_have_nxt;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [ADDR_W-1:0] aw_addr_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [DATA_W-1:0] w_data_r;
    logic [DATA_W-1:0] w_data_nxt;
    logic [3:0] w_strb_r;
    logic [3:0] w_strb_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic aw_ok;
    logic w_ok;
    logic do_wr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_lane0;
    logic [2:0] cmd_sel;

    assign awready = ce && (wr_state_r == WR_IDLE) && !aw_have_r;
    assign wready = ce && (wr_state_r == WR_IDLE) && !w_have_r;
    assign aw_ok = aw_have_r || (awvalid && awready);
    assign w_ok = w_have_r || (wvalid && wready);
    assign do_wr = ce && (wr_state_r == WR_IDLE) && aw_ok && w_ok;
    assign wr_addr = aw_have_r ? aw_addr_r : awaddr;
    assign wr_data = w_have_r ? w_data_r : wdata;
    assign wr_lane0 = w_have_r ? w_strb_r[0] : wstrb[0];
    assign cmd_sel = wr_data[PINCMD_SEL_LSB +: 3];
    assign bvalid = (wr_state_r == WR_RESP);
    assign bresp = bresp_r;

    always_comb begin
        wr_state_nxt = wr_state_r;
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt = w_have_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bresp_nxt = bresp_r;
        if (ce) begin
            unique case (wr_state_r)
                WR_IDLE: begin
                    if (do_wr) begin
                        aw_have_nxt = 1'b0;
                        w_have_nxt = 1'b0;
                        bresp_nxt = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
                        wr_state_nxt = WR_RESP;
                    end else begin
                        if (awvalid && awready) begin
                            aw_have_nxt = 1'b1;
                            aw_addr_nxt = awaddr;
                        end
                        if (wvalid && wready) begin
                            w_have_nxt = 1'b1;
                            w_data_nxt = wdata;
                            w_strb_nxt = wstrb;
                        end
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        wr_state_nxt = WR_IDLE;
                    end
                end
                default: begin
                    wr_state_nxt = WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_state_r <= WR_IDLE;
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_have_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bresp_r <= RESP_OKAY;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r <= w_have_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // register updates; refresh beats any raw tristate write
    assign refresh = (refresh_cnt_r == '0);

    always_comb begin
        dir_nxt = dir_r;
        tris_hw_nxt = tris_hw_r;
        lvl_nxt = lvl_r;
        fixed_nxt = fixed_r;
        anmode_nxt = anmode_r;
        sfen_nxt = sfen_r;
        refresh_cnt_nxt = refresh_cnt_r;
        if (ce) begin
            refresh_cnt_nxt = refresh ? CNT_W'(REFRESH_CYCLES - 1) : refresh_cnt_r - 1'b1;
            if (do_wr && wr_lane0) begin
                unique case (wr_addr)
                    OFF_DIR: begin
                        dir_nxt = wr_data[C_W-1:0];
                    end
                    OFF_TRIS: begin
                        dir_nxt = ~wr_data[C_W-1:0];
                    end
                    OFF_LVL: begin
                        lvl_nxt = wr_data[C_W-1:0];
                    end
                    OFF_FIXED: begin
                        fixed_nxt = wr_data[C_W-1:0];
                    end
                    OFF_ANMODE: begin
                        anmode_nxt = wr_data[A_W-1:0];
                    end
                    OFF_PINCMD: begin
                        dir_nxt[cmd_sel] = 1'b1;
                        lvl_nxt[cmd_sel] = wr_data[PINCMD_LVL_BIT];
                    end
                    OFF_SFEN: begin
                        sfen_nxt = wr_data[3:0];
                    end
                    OFF_RAWTRIS: begin
                        tris_hw_nxt = wr_data[C_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            // firmware copy wins over the raw hardware setting
            if (refresh || (dir_nxt != dir_r)) begin
                tris_hw_nxt = ~dir_nxt;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_r <= RST_DIR;
            tris_hw_r <= RST_TRIS;
            lvl_r <= RST_LVL;
            fixed_r <= RST_FIXED;
            anmode_r <= RST_ANMODE;
            sfen_r <= RST_SFEN;
            refresh_cnt_r <= CNT_W'(REFRESH_CYCLES - 1);
        end else begin
            dir_r <= dir_nxt;
            tris_hw_r <= tris_hw_nxt;
            lvl_r <= lvl_nxt;
            fixed_r <= fixed_nxt;
            anmode_r <= anmode_nxt;
            sfen_r <= sfen_nxt;
            refresh_cnt_r <= refresh_cnt_nxt;
        end
    end

    // read channel
    logic rvalid_r;
    logic rvalid_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic [C_W-1:0] rd_byte;

    assign arready = ce && !rvalid_r;

    always_comb begin
        unique case (araddr)
            OFF_DIR: rd_byte = dir_r;
            OFF_TRIS: rd_byte = ~dir_r;
            OFF_LVL: rd_byte = third_sync;
            OFF_FIXED: rd_byte = fixed_r;
            OFF_FIRST: rd_byte = {4'h0, first_sync};
            OFF_ANMODE: rd_byte = {4'h0, anmode_r};
            OFF_SFEN: rd_byte = {4'h0, sfen_r};
            OFF_RAWTRIS: rd_byte = tris_hw_r;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (ce) begin
            if (rvalid_r && rready) begin
                rvalid_nxt = 1'b0;
            end
            if (arvalid && arready) begin
                rvalid_nxt = 1'b1;
                rdata_nxt = {24'h000000, rd_byte};
                rresp_nxt = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // pin drive
    pin_function_mux u_mux (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .lvl(lvl_r),
        .tris_hw(tris_hw_r),
        .sf_en(sfen_r),
        .drive(sf_drive),
        .pin_out(third_out),
        .pin_oe(third_oe)
    );

    assign fixed_output_port = fixed_r;
    assign first_analog_sel = anmode_r;
    assign sf_sense = '{ir: third_sync[PIN_IR], scl: third_sync[PIN_SCL], sda: third_sync[PIN_SDA],
        kbd_clk: third_sync[PIN_KCLK], kbd_data: third_sync[PIN_KDAT]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_reset_state: assert property ($rose(rst_n) |-> dir_r == 8'h00 && third_oe == 8'h00)
        else $error("third port not all inputs after reset");
    chk_analog_reset: assert property ($rose(rst_n) |-> first_analog_sel == 4'hF)
        else $error("first port not analogue after reset");
    chk_first_read: assert property (ce && arvalid && arready && araddr == OFF_FIRST
        |=> rdata == {28'h0000000, $past(first_sync)})
        else $error("first port digital read wrong");
    chk_fixed_write: assert property (do_wr && wr_lane0 && wr_addr == OFF_FIXED
        |=> fixed_output_port == $past(wr_data[7:0]))
        else $error("fixed port not updated");
    chk_dir_sense: assert property (ce && sfen_r == 4'h0 && tris_hw_r == ~dir_r
        |=> third_oe == $past(dir_r))
        else $error("direction sense wrong");
    chk_tris_view: assert property (do_wr && wr_lane0 && wr_addr == OFF_TRIS
        |=> dir_r == ~$past(wr_data[7:0]) ##1 !ce || third_oe == ~$past(wr_data[7:0], 2))
        else $error("tristate view not inverted");
    chk_raw_refresh: assert property (ce && refresh |=> tris_hw_r == ~dir_r)
        else $error("raw tristate survived refresh");
    chk_pin_cmd: assert property (do_wr && wr_lane0 && wr_addr == OFF_PINCMD
        |=> dir_r[$past(cmd_sel)] && lvl_r[$past(cmd_sel)] == $past(wr_data[PINCMD_LVL_BIT]))
        else $error("pin command did not set direction and level");
    chk_level_write: assert property (do_wr && wr_lane0 && wr_addr == OFF_LVL
        |=> lvl_r == $past(wr_data[7:0]))
        else $error("level write lost");
    chk_pwm_takeover: assert property (ce && sfen_r[SF_PWM]
        |=> third_oe[2:1] == 2'b11 && third_out[2:1] == $past(sf_drive.pwm))
        else $error("pwm pins not taken over");
    chk_latch_hold: assert property (ce && !(do_wr && wr_lane0 && (wr_addr == OFF_LVL || wr_addr == OFF_PINCMD))
        |=> $stable(lvl_r))
        else $error("level latch changed without write");
    chk_bresp_bound: assert property (do_wr |=> bvalid)
        else $error("write response missing");

    cov_pin_cmd: cover property (do_wr && wr_addr == OFF_PINCMD);
    cov_raw_then_refresh: cover property (do_wr && wr_addr == OFF_RAWTRIS ##[1:300] refresh);
    cov_read_levels: cover property (arvalid && arready && araddr == OFF_LVL);
    cov_i2c_pull: cover property (sfen_r[SF_I2C] && third_oe[PIN_SCL]);
endmodule : configurable_io_ports

// ### tb/pin_loads.sv
// pin-side model: switches and loads on the third port
`timescale 1ns/1ps
module pin_loads (
    input wire logic [7:0] third_out,
    input wire logic [7:0] third_oe,
    input wire logic [7:0] sw,
    output logic [7:0] third_in
);
    // a driven pin follows the device, a released one falls back to its switch or pull resistor
    assign third_in = (third_oe & third_out) | (~third_oe & sw);
endmodule : pin_loads

// ### tb/configurable_io_ports_tb.sv
// self-checking bench for the configurable io port block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module configurable_io_ports_tb;
    import io_ports_pkg::*;
    // short refresh keeps the raw-write scenario brief
    localparam int REFR = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [A_W-1:0] first_in = 4'h0;
    logic [A_W-1:0] first_analog_sel;
    logic [C_W-1:0] fixed_output_port, third_in, third_out, third_oe;
    logic [C_W-1:0] sw = 8'h00;
    sf_drive_t sf_drive = '0;
    sf_sense_t sf_sense;
    int err_count = 0;
    int n_tests = 0;

    always #2.5 clk = ~clk;

    configurable_io_ports #(.REFRESH_CYCLES(REFR)) configurable_io_ports_inst (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .first_in(first_in), .first_analog_sel(first_analog_sel), .fixed_output_port(fixed_output_port),
        .third_in(third_in), .third_out(third_out), .third_oe(third_oe),
        .sf_drive(sf_drive), .sf_sense(sf_sense)
    );

    pin_loads pin_loads_inst (.third_out(third_out), .third_oe(third_oe), .sw(sw), .third_in(third_in));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h0, d};
        bready <= 1'b1;
        // address and data may be taken on different edges
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (!((awvalid === 1'b0 || awready === 1'b1) && (wvalid === 1'b0 || wready === 1'b1)));
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        @(posedge clk);
    endtask : rd

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK("rresp", RESP_OKAY, r)
        `CHK("rdata", {24'h0, e}, d)
    endtask : rd_chk

    function automatic logic [7:0] pin_lvl(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] s);
        return (oe & out) | (~oe & s);
    endfunction : pin_lvl

    function automatic logic [7:0] cmd_lvl(input logic [7:0] lvl, input logic [3:0] c);
        return c[3] ? (lvl | (8'h01 << c[2:0])) : (lvl & ~(8'h01 << c[2:0]));
    endfunction : cmd_lvl

    initial begin
        #(20000 * 5);
        err_count++;
        report_and_stop();
    end

    initial begin
        logic [7:0] d, l, v;
        logic [3:0] c;
        logic [31:0] rdv;
        logic [1:0] rr;
        sf_sense_t s;
        void'($urandom(32'h2FE06349));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("oe_rst", RST_DIR, third_oe)
        `CHK("anmode_rst", RST_ANMODE, first_analog_sel)
        `CHK("fixed_rst", RST_FIXED, fixed_output_port)
        rd_chk(OFF_DIR, RST_DIR);
        rd_chk(OFF_TRIS, RST_TRIS);
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom);
            first_in <= v[3:0];
            wr(OFF_FIXED, v, RESP_OKAY);
            `CHK("fixed", v, fixed_output_port)
            wr(OFF_ANMODE, {4'h0, ~v[3:0]}, RESP_OKAY);
            `CHK("anmode", ~v[3:0], first_analog_sel)
            rd_chk(OFF_FIRST, {4'h0, v[3:0]});
        end
        // level written before direction: the latch must survive the turn to output
        for (int i = 0; i < 12; i++) begin
            d = (i < 2) ? 8'hFF : 8'($urandom);
            l = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            sw <= 8'($urandom);
            wr(OFF_LVL, l, RESP_OKAY);
            if (i[0]) wr(OFF_TRIS, ~d, RESP_OKAY);
            else wr(OFF_DIR, d, RESP_OKAY);
            rd_chk(OFF_DIR, d);
            rd_chk(OFF_TRIS, ~d);
            `CHK("oe", d, third_oe)
            `CHK("out", d & l, third_out & d)
            rd_chk(OFF_LVL, pin_lvl(d, l, sw));
        end
        wr(OFF_DIR, 8'h00, RESP_OKAY);
        d = 8'h00;
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            wr(OFF_PINCMD, {4'h0, c}, RESP_OKAY);
            d = d | (8'h01 << c[2:0]);
            l = cmd_lvl(l, c);
            repeat (2) @(posedge clk);
            `CHK("cmd_oe", d, third_oe)
            `CHK("cmd_out", d & l, third_out & d)
        end
        d = 8'($urandom);
        wr(OFF_DIR, d, RESP_OKAY);
        wr(OFF_RAWTRIS, d, RESP_OKAY);
        repeat (REFR + 4) @(posedge clk);
        rd_chk(OFF_RAWTRIS, ~d);
        `CHK("raw_oe", d, third_oe)
        wr(6'h3C, 8'h55, RESP_SLVERR);
        rd(6'h3C, rdv, rr);
        `CHK("rresp", RESP_SLVERR, rr)
        `CHK("rdata", 32'h0, rdv)
        // special functions must override a direction of all outputs
        wr(OFF_DIR, 8'hFF, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            l = 8'($urandom);
            sw <= 8'($urandom);
            sf_drive <= sf_drive_t'(4'($urandom));
            wr(OFF_LVL, l, RESP_OKAY);
            wr(OFF_SFEN, 8'h0F, RESP_OKAY);
            repeat (4) @(posedge clk);
            v = {3'b001, sf_drive.sda_low, sf_drive.scl_low, 3'b110};
            `CHK("sf_oe", v, third_oe)
            `CHK("pwm", sf_drive.pwm, third_out[2:1])
            `CHK("i2c_out", 2'b00, third_out[4:3])
            `CHK("plain_out", l[5], third_out[5])
            d = pin_lvl(v, {l[7:5], 2'b00, sf_drive.pwm, l[0]}, sw);
            `CHK("sense", {d[0], d[3], d[4], d[6], d[7]}, sf_sense)
        end
        // enable low: bus must stall, synchronisers and registers must hold
        l = fixed_output_port;
        s = sf_sense;
        ce <= 1'b0;
        sw <= ~sw;
        fork
            wr(OFF_FIXED, ~l, RESP_OKAY);
            begin
                repeat (6) @(posedge clk);
                `CHK("ce_fixed_hold", l, fixed_output_port)
                `CHK("ce_sense_hold", s, sf_sense)
                ce <= 1'b1;
            end
        join
        `CHK("ce_fixed", ~l, fixed_output_port)
        // lane 0 strobe off: write answered but ignored
        wstrb <= 4'hE;
        wr(OFF_FIXED, l, RESP_OKAY);
        `CHK("lane0_off", ~l, fixed_output_port)
        wstrb <= 4'hF;
        // second reset in mid-run must restore the power-up arrangement
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("oe_rst2", 8'h00, third_oe)
        `CHK("fixed_rst2", RST_FIXED, fixed_output_port)
        `CHK("anmode_rst2", RST_ANMODE, first_analog_sel)
        rd_chk(OFF_DIR, RST_DIR);
        report_and_stop();
    end
endmodule : configurable_io_ports_tb
